// ### rtl/flash_pkg.sv
// Shared constants and types for the flash self-programming controller.
package flash_pkg;

  // ----------------------------------------------------------------------
  // Register addresses on the plain register port
  // ----------------------------------------------------------------------
  localparam logic [2:0] REG_CONTROL = 3'h0;
  localparam logic [2:0] REG_ADDR_LOW = 3'h1;
  localparam logic [2:0] REG_ADDR_UPPER = 3'h2;
  localparam logic [2:0] REG_UNLOCK_KEY = 3'h3;
  localparam logic [2:0] REG_TABLE_PAGE = 3'h4;

  // ----------------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_TRIGGER_BIT = 15;
  localparam int CTRL_PERMIT_BIT = 14;
  localparam int CTRL_ABORT_BIT = 13;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 7;
  localparam logic CTRL_PERMIT_RESET = 1'b0;
  localparam logic CTRL_ABORT_RESET = 1'b0;
  localparam logic [6:0] CTRL_OP_RESET = 7'h00;
  localparam logic [6:0] OP_ROW_ERASE = 7'h41;
  localparam logic [6:0] OP_ROW_PROGRAM = 7'h01;
  localparam logic [15:0] ADDR_LOW_RESET = 16'h0000;
  localparam logic [7:0] ADDR_UPPER_RESET = 8'h00;
  localparam logic [15:0] TABLE_PAGE_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // Unlock keys
  // ----------------------------------------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;

  // ----------------------------------------------------------------------
  // Array organisation
  // ----------------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam int ROW_WORDS = 32;
  localparam int PANEL_ROWS = 128;
  localparam int LATCH_IDX_W = 5;
  localparam int ROW_SEL_W = 7;
  localparam int PANEL_SEL_W = 11;
  localparam int ROW_SEL_LSB = 6;
  localparam int PANEL_SEL_LSB = 13;
  localparam logic [23:0] LATCH_RESET = 24'hffffff;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned OP_TIME_US = 2000;
  localparam int unsigned CLK_KHZ = 20000;
  localparam int unsigned OP_CYCLES = OP_TIME_US * CLK_KHZ / 1000;
  localparam logic [1:0] TBL_WRITE_CYCLES = 2'h2;
  localparam logic [1:0] TBL_READ_CYCLES = 2'h1;

  typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} key_state_t;
  typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_PROGRAM} op_state_t;

endpackage

// ### rtl/write_latch_bank.sv
// Row write latches: 32 program words with per-byte write enables.
`timescale 1ns/10ps
module write_latch_bank (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [4:0] wr_idx,
  input wire logic [2:0] wr_be,
  input wire logic [23:0] wr_data,
  input wire logic [4:0] rd_idx,
  output logic [23:0] rd_data
);

  logic [23:0] word_store [flash_pkg::ROW_WORDS];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < flash_pkg::ROW_WORDS; i++) begin
        word_store[i] <= flash_pkg::LATCH_RESET;
      end
      rd_data <= flash_pkg::LATCH_RESET;
    end else if (ce) begin
      for (int b = 0; b < 3; b++) begin
        if (wr_en && wr_be[b]) begin
          word_store[wr_idx][b*8 +: 8] <= wr_data[b*8 +: 8];
        end
      end
      rd_data <= word_store[rd_idx];
    end
  end

endmodule

// ### rtl/flash_self_program_controller.sv
// Run-time self-programming controller for the on-chip program flash.
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/10ps

// Functional notes
// - Erase one row, program one 32-word row.
// - Rows of 32 words, panels of 128 rows.
// - Low table access reaches bits 15..0.
// - High table access reaches bits 23..16.
// - Address is page low byte plus offset.
// - Latches hold 32 words indexed by offset bits 5..1.
// - Table writes hit latches only, two cycles.
// - Low address captures offset of table access.
// - Upper address captures page of table access.
// - Software may write both address registers directly.
// - Key write-only; 0x55 then 0xAA unlocks.
// - Operation lasts 2 ms, processor stalled throughout.
// - Trigger bit starts, hardware clears at end.
// - Control selects operation and holds trigger.
// - High write stores only source low byte.
// - Permit bit gates operations, clear after power-up.
// - Warm reset during operation sets abort flag.
// - Software cannot clear the trigger bit.
module flash_self_program_controller #(
  parameter int unsigned OP_CYCLES_P = flash_pkg::OP_CYCLES
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic tbl_valid,
  input wire logic tbl_write,
  input wire logic tbl_high,
  input wire logic tbl_byte,
  input wire logic tbl_odd,
  input wire logic [15:0] tbl_offset,
  input wire logic [15:0] tbl_wdata,
  output logic tbl_ready,
  output logic tbl_done,
  output logic [15:0] tbl_rdata,
  output logic [23:0] array_raddr,
  input wire logic [23:0] array_rdata,
  input wire logic warm_reset,
  output logic cpu_stall,
  output logic array_erase,
  output logic array_program,
  output logic [10:0] array_panel,
  output logic [6:0] array_row,
  input wire logic [4:0] latch_idx,
  output logic [23:0] latch_data
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  flash_pkg::op_state_t op_state;
  flash_pkg::key_state_t key_state;
  logic permit;
  logic abort_flag;
  logic [6:0] op_sel;
  logic [15:0] address_low;
  logic [7:0] address_upper;
  logic [15:0] table_page;
  logic [15:0] op_cnt;
  logic [1:0] tbl_cnt;

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  wire busy = (op_state != flash_pkg::OP_IDLE);
  wire wr_ctrl = reg_write && (reg_addr == flash_pkg::REG_CONTROL);
  wire wr_low = reg_write && (reg_addr == flash_pkg::REG_ADDR_LOW);
  wire wr_upper = reg_write && (reg_addr == flash_pkg::REG_ADDR_UPPER);
  wire wr_key = reg_write && (reg_addr == flash_pkg::REG_UNLOCK_KEY);
  wire wr_page = reg_write && (reg_addr == flash_pkg::REG_TABLE_PAGE);
  wire [6:0] new_op = reg_wdata[flash_pkg::CTRL_OP_LSB +: flash_pkg::CTRL_OP_W];
  wire op_is_erase = (new_op == flash_pkg::OP_ROW_ERASE);
  wire op_is_prog = (new_op == flash_pkg::OP_ROW_PROGRAM);
  // A start needs the keys in the two writes just before, permit set in the
  // same write, and a row operation; anything else leaves the array alone.
  wire start_req = wr_ctrl && reg_wdata[flash_pkg::CTRL_TRIGGER_BIT]
    && reg_wdata[flash_pkg::CTRL_PERMIT_BIT]
    && (key_state == flash_pkg::KEY_ARMED) && !busy && !warm_reset
    && (op_is_erase || op_is_prog);
  wire op_end = busy && (op_cnt == 16'h0000);
  wire [15:0] op_load = 16'(OP_CYCLES_P - 1);

  // Table access is refused while an operation runs; the core is stalled.
  assign tbl_ready = !busy && (tbl_cnt <= 2'h1);
  assign tbl_done = (tbl_cnt == 2'h1);
  wire tbl_take = ce && tbl_valid && tbl_ready;
  assign array_raddr = {table_page[7:0], tbl_offset};

  // Byte lanes: lane 2 holds bits 23..16, lanes 1 and 0 the low half.
  wire [2:0] be_low = tbl_byte ? (tbl_odd ? 3'h2 : 3'h1) : 3'h3;
  wire [2:0] be_high = (tbl_byte && tbl_odd) ? 3'h0 : 3'h4;
  wire [2:0] latch_be = tbl_high ? be_high : be_low;
  wire [15:0] low_src = tbl_byte ? {tbl_wdata[7:0], tbl_wdata[7:0]}
    : tbl_wdata;
  // Only the low byte of the source reaches the top lane.
  wire [23:0] latch_wdata = {tbl_wdata[7:0], low_src};
  wire latch_we = tbl_take && tbl_write;
  // Word index follows the offset, so loads may start anywhere in the row.
  wire [4:0] latch_widx = tbl_offset[5:1];

  wire [15:0] rd_low = tbl_byte
    ? {8'h00, (tbl_odd ? array_rdata[15:8] : array_rdata[7:0])}
    : array_rdata[15:0];
  wire [15:0] rd_high = (tbl_byte && tbl_odd) ? 16'h0000
    : {8'h00, array_rdata[23:16]};
  wire [15:0] next_tbl_rdata = tbl_high ? rd_high : rd_low;

  wire [15:0] ctrl_view = {busy, permit, abort_flag, 6'h00, op_sel};
  wire [15:0] next_reg_rdata =
    (reg_addr == flash_pkg::REG_CONTROL) ? ctrl_view :
    (reg_addr == flash_pkg::REG_ADDR_LOW) ? address_low :
    (reg_addr == flash_pkg::REG_ADDR_UPPER) ? {8'h00, address_upper} :
    (reg_addr == flash_pkg::REG_TABLE_PAGE) ? table_page :
    16'h0000;

  // Row and panel selection for the array come from the address registers.
  wire [23:0] row_addr = {address_upper, address_low};
  assign array_panel = row_addr[flash_pkg::PANEL_SEL_LSB +:
    flash_pkg::PANEL_SEL_W];
  assign array_row = row_addr[flash_pkg::ROW_SEL_LSB +:
    flash_pkg::ROW_SEL_W];
  assign array_erase = (op_state == flash_pkg::OP_ERASE);
  assign array_program = (op_state == flash_pkg::OP_PROGRAM);
  assign cpu_stall = busy;

  // ----------------------------------------------------------------------
  // Operation sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      op_state <= flash_pkg::OP_IDLE;
      op_cnt <= 16'h0000;
    end else if (ce) begin
      unique case (op_state)
        flash_pkg::OP_IDLE: begin
          if (start_req) begin
            op_state <= op_is_erase ? flash_pkg::OP_ERASE
              : flash_pkg::OP_PROGRAM;
            op_cnt <= op_load;
          end
        end
        flash_pkg::OP_ERASE, flash_pkg::OP_PROGRAM: begin
          // A zero written to the trigger has no path here.
          if (warm_reset || op_end) begin
            op_state <= flash_pkg::OP_IDLE;
          end else begin
            op_cnt <= op_cnt - 16'h0001;
          end
        end
        default: begin
          op_state <= flash_pkg::OP_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Control bits and unlock tracking
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      permit <= flash_pkg::CTRL_PERMIT_RESET;
      abort_flag <= flash_pkg::CTRL_ABORT_RESET;
      op_sel <= flash_pkg::CTRL_OP_RESET;
      key_state <= flash_pkg::KEY_IDLE;
    end else if (ce) begin
      if (warm_reset) begin
        permit <= flash_pkg::CTRL_PERMIT_RESET;
        op_sel <= flash_pkg::CTRL_OP_RESET;
        key_state <= flash_pkg::KEY_IDLE;
        if (busy) begin
          abort_flag <= 1'b1;
        end
      end else begin
        if (wr_ctrl && !busy) begin
          permit <= reg_wdata[flash_pkg::CTRL_PERMIT_BIT];
          abort_flag <= reg_wdata[flash_pkg::CTRL_ABORT_BIT];
          op_sel <= new_op;
        end
        if (wr_key && (reg_wdata[7:0] == flash_pkg::KEY_FIRST)) begin
          key_state <= flash_pkg::KEY_GOT_FIRST;
        end else if (wr_key && (reg_wdata[7:0] == flash_pkg::KEY_SECOND)
            && (key_state == flash_pkg::KEY_GOT_FIRST)) begin
          key_state <= flash_pkg::KEY_ARMED;
        end else if (reg_write || latch_we) begin
          key_state <= flash_pkg::KEY_IDLE;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Address, page and table timing
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      address_low <= flash_pkg::ADDR_LOW_RESET;
      address_upper <= flash_pkg::ADDR_UPPER_RESET;
      table_page <= flash_pkg::TABLE_PAGE_RESET;
      tbl_cnt <= 2'h0;
      tbl_rdata <= 16'h0000;
      reg_rdata <= 16'h0000;
    end else if (ce) begin
      // Warm reset leaves the address registers untouched.
      if (wr_low) begin
        address_low <= reg_wdata;
      end else if (tbl_take) begin
        address_low <= tbl_offset;
      end
      if (wr_upper) begin
        address_upper <= reg_wdata[7:0];
      end else if (tbl_take) begin
        address_upper <= table_page[7:0];
      end
      if (wr_page) begin
        table_page <= reg_wdata;
      end
      if (tbl_take) begin
        tbl_cnt <= tbl_write ? flash_pkg::TBL_WRITE_CYCLES
          : flash_pkg::TBL_READ_CYCLES;
      end else if (tbl_cnt != 2'h0) begin
        tbl_cnt <= tbl_cnt - 2'h1;
      end
      if (tbl_take && !tbl_write) begin
        tbl_rdata <= next_tbl_rdata;
      end
      reg_rdata <= reg_read ? next_reg_rdata : 16'h0000;
    end
  end

  write_latch_bank latches (
    .clk_sys(clk_sys),
    .srst(srst),
    .ce(ce),
    .wr_en(latch_we),
    .wr_idx(latch_widx),
    .wr_be(latch_be),
    .wr_data(latch_wdata),
    .rd_idx(latch_idx),
    .rd_data(latch_data)
  );

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst || !ce);

  a_start_needs_key: assert property (
    $rose(busy) |-> $past(key_state) == flash_pkg::KEY_ARMED)
    else $error("operation started without unlock");
  a_start_permit: assert property (
    $rose(busy) |-> permit && (op_cnt == op_load))
    else $error("operation started without permit or bad count");
  a_op_end: assert property (
    (op_end && !warm_reset) |=> !busy && !cpu_stall)
    else $error("trigger not cleared at end of operation");
  a_no_sw_clear: assert property (
    (busy && (op_cnt != 16'h0000) && !warm_reset) |=> busy)
    else $error("operation ended early");
  a_stall_hold: assert property (
    $rose(cpu_stall) && (op_cnt > 16'h0008) |-> cpu_stall[*8])
    else $error("stall dropped during operation");
  a_abort_sets: assert property (
    (warm_reset && busy) |=> abort_flag && !busy
      && (address_low == $past(address_low)))
    else $error("abort not recorded or address lost");
  a_addr_capture: assert property (
    (tbl_take && !reg_write) |=> (address_low == $past(tbl_offset))
      && (address_upper == $past(table_page[7:0])))
    else $error("table address not captured");
  a_write_time: assert property (
    (tbl_take && tbl_write) |=> !tbl_done ##1 tbl_done)
    else $error("table write did not take two cycles");
  a_read_high: assert property (
    (tbl_take && !tbl_write && tbl_high && !tbl_byte) |=>
      tbl_done && (tbl_rdata == {8'h00, $past(array_rdata[23:16])}))
    else $error("high read returned wrong bits");
  a_key_order: assert property (
    (wr_key && (key_state == flash_pkg::KEY_IDLE) && !warm_reset) |=>
      key_state != flash_pkg::KEY_ARMED)
    else $error("unlock armed without first key");

endmodule

// ### verification/flash_array_model.sv
// Program array model that answers the controller's read and latch ports.
`timescale 1ns/10ps
module flash_array_model (
  input wire logic clk_sys,
  input wire logic [23:0] array_raddr,
  output logic [23:0] array_rdata,
  input wire logic array_program,
  input wire logic [4:0] idx_sel,
  output logic [4:0] latch_idx
);
  logic [4:0] walk = 5'h00;

  // The content is a fixed pattern of the address, so every read is
  // predictable and a wrong page or offset shows up as wrong data.
  assign array_rdata = {array_raddr[23:16] ^ array_raddr[7:0] ^ 8'h3c,
    ~array_raddr[15:0]};

  // While a row is programmed the model walks the whole row of latches.
  always_ff @(posedge clk_sys) begin
    walk <= array_program ? walk + 5'h01 : 5'h00;
  end
  assign latch_idx = array_program ? walk : idx_sel;
endmodule

// ### verification/test_flash_self_program_controller.sv
// Self-checking bench for the flash self-programming controller.
`timescale 1ns/10ps
module test_flash_self_program_controller;
  localparam int OPC = 20;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic tbl_valid = 1'b0;
  logic tbl_write = 1'b0;
  logic tbl_high = 1'b0;
  logic tbl_byte = 1'b0;
  logic tbl_odd = 1'b0;
  logic [15:0] tbl_offset = 16'h0000;
  logic [15:0] tbl_wdata = 16'h0000;
  logic tbl_ready, tbl_done, cpu_stall, array_erase, array_program;
  logic [15:0] tbl_rdata;
  logic [23:0] array_raddr, array_rdata, latch_data;
  logic warm_reset = 1'b0;
  logic [10:0] array_panel;
  logic [6:0] array_row;
  logic [4:0] latch_idx;
  logic [4:0] lsel = 5'h00;
  logic [15:0] rv;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int stall_n = 0;
  int prog_n = 0;
  int erase_n = 0;

  flash_self_program_controller #(.OP_CYCLES_P(OPC)) dut_u (
    .clk_sys(clk_sys), .srst(srst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .tbl_valid(tbl_valid), .tbl_write(tbl_write),
    .tbl_high(tbl_high), .tbl_byte(tbl_byte), .tbl_odd(tbl_odd),
    .tbl_offset(tbl_offset), .tbl_wdata(tbl_wdata), .tbl_ready(tbl_ready),
    .tbl_done(tbl_done), .tbl_rdata(tbl_rdata), .array_raddr(array_raddr),
    .array_rdata(array_rdata), .warm_reset(warm_reset),
    .cpu_stall(cpu_stall), .array_erase(array_erase),
    .array_program(array_program), .array_panel(array_panel),
    .array_row(array_row), .latch_idx(latch_idx), .latch_data(latch_data));

  flash_array_model array_u (
    .clk_sys(clk_sys), .array_raddr(array_raddr), .array_rdata(array_rdata),
    .array_program(array_program), .idx_sel(lsel), .latch_idx(latch_idx));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // Operation lengths are counted here so the tasks can judge them later.
  always @(posedge clk_sys) begin
    cyc++;
    if (cpu_stall === 1'b1) stall_n++;
    if (array_program === 1'b1) prog_n++;
    if (array_erase === 1'b1) erase_n++;
    if (cyc == 3000) begin
      err_total++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------
  task chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task chk1(input string nm, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // Writes may follow each other; idle() drops the strobe afterwards.
  task wr(input logic [2:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    reg_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  task idle(input int n);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask

  task rd(input logic [2:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    reg_write <= 1'b0;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
    @(posedge clk_sys);
  endtask

  task tbl(input logic w, input logic h, input logic [15:0] off,
           input logic [15:0] d);
    tbl_valid <= 1'b1;
    tbl_write <= w;
    tbl_high <= h;
    tbl_offset <= off;
    tbl_wdata <= d;
    @(negedge clk_sys);
    for (int i = 0; i < 50 && tbl_ready !== 1'b1; i++) @(negedge clk_sys);
    @(posedge clk_sys);
    tbl_valid <= 1'b0;
    @(negedge clk_sys);
    if (w) begin
      chk1("tbl_done early", 1'b0, tbl_done);
      @(negedge clk_sys);
    end
    chk1("tbl_done", 1'b1, tbl_done);
    @(posedge clk_sys);
  endtask

  // Nothing else may touch the registers inside the sequence.
  task unlock(input logic [15:0] start);
    stall_n = 0;
    prog_n = 0;
    erase_n = 0;
    wr(flash_pkg::REG_UNLOCK_KEY, {8'h00, flash_pkg::KEY_FIRST});
    wr(flash_pkg::REG_UNLOCK_KEY, {8'h00, flash_pkg::KEY_SECOND});
    wr(flash_pkg::REG_CONTROL, start);
    idle(2);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_reset;
    for (int a = 0; a < 6; a++) begin
      rd(3'(a), rv);
      chk("reset read", 24'h000000, 24'(rv));
    end
    $display("test reset done");
  endtask

  // The page byte enters the model's data, so a lost page shows up here.
  task t_table_read;
    wr(flash_pkg::REG_TABLE_PAGE, 16'h0012);
    idle(1);
    tbl(1'b0, 1'b0, 16'h0a04, 16'h0000);
    chk("read low", 24'h00f5fb, 24'(tbl_rdata));
    tbl(1'b0, 1'b1, 16'h0a04, 16'h0000);
    chk("read high", 24'h00002a, 24'(tbl_rdata));
    tbl_byte <= 1'b1;
    tbl_odd <= 1'b1;
    tbl(1'b0, 1'b0, 16'h0a04, 16'h0000);
    chk("read odd byte", 24'h0000f5, 24'(tbl_rdata));
    tbl(1'b0, 1'b1, 16'h0a04, 16'h0000);
    chk("read high odd", 24'h000000, 24'(tbl_rdata));
    tbl_odd <= 1'b0;
    tbl(1'b0, 1'b1, 16'h0a04, 16'h0000);
    chk("read high byte", 24'h00002a, 24'(tbl_rdata));
    tbl_byte <= 1'b0;
    rd(flash_pkg::REG_ADDR_LOW, rv);
    chk("addr low", 24'h000a04, 24'(rv));
    rd(flash_pkg::REG_ADDR_UPPER, rv);
    chk("addr upper", 24'h000012, 24'(rv));
    $display("test table read done");
  endtask

  task t_fill;
    int pick[3];
    pick = '{0, 17, 31};
    wr(flash_pkg::REG_TABLE_PAGE, 16'h0000);
    idle(1);
    for (int i = 0; i < 32; i++) begin
      tbl(1'b1, 1'b0, 16'h6040 + 16'(2 * i), 16'hc300 + 16'(i));
      tbl(1'b1, 1'b1, 16'h6040 + 16'(2 * i), 16'hab00 + 16'(i));
    end
    for (int k = 0; k < 3; k++) begin
      lsel <= 5'(pick[k]);
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk("latch word", {8'(pick[k]), 16'(16'hc300 + pick[k])},
          latch_data);
      @(posedge clk_sys);
    end
    // Odd low byte replaces bits 15..8; odd high byte must change nothing.
    tbl_byte <= 1'b1;
    tbl_odd <= 1'b1;
    tbl(1'b1, 1'b0, 16'h6062, 16'h005a);
    tbl(1'b1, 1'b1, 16'h6062, 16'h0077);
    tbl_byte <= 1'b0;
    tbl_odd <= 1'b0;
    lsel <= 5'h11;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("latch byte", 24'h115a11, latch_data);
    @(posedge clk_sys);
    $display("test latch fill done");
  endtask

  task t_locked;
    stall_n = 0;
    prog_n = 0;
    wr(flash_pkg::REG_UNLOCK_KEY, 16'h0055);
    wr(flash_pkg::REG_ADDR_LOW, 16'h607e);
    wr(flash_pkg::REG_UNLOCK_KEY, 16'h00aa);
    wr(flash_pkg::REG_CONTROL, 16'hc001);
    idle(4);
    chk("broken unlock", 24'h000000, 24'(prog_n));
    unlock(16'h8001);
    idle(4);
    chk("no permit", 24'h000000, 24'(prog_n + stall_n));
    $display("test locked done");
  endtask

  // Three frozen cycles in mid-operation must stretch it by three.
  task t_program;
    wr(flash_pkg::REG_CONTROL, 16'h4001);
    unlock(16'hc001);
    @(negedge clk_sys);
    chk1("stall", 1'b1, cpu_stall);
    chk("panel", 24'h000003, 24'(array_panel));
    chk("row", 24'h000001, 24'(array_row));
    @(posedge clk_sys);
    wr(flash_pkg::REG_CONTROL, 16'h4001);
    idle(1);
    rd(flash_pkg::REG_CONTROL, rv);
    chk1("busy bit", 1'b1, rv[15]);
    ce <= 1'b0;
    idle(3);
    ce <= 1'b1;
    idle(OPC + 5);
    chk("program cycles", 24'(OPC + 3), 24'(prog_n));
    chk("stall cycles", 24'(OPC + 3), 24'(stall_n));
    rd(flash_pkg::REG_CONTROL, rv);
    chk1("trigger clear", 1'b0, rv[15]);
    $display("test program done");
  endtask

  task t_erase;
    wr(flash_pkg::REG_ADDR_UPPER, 16'h0001);
    wr(flash_pkg::REG_ADDR_LOW, 16'h2080);
    wr(flash_pkg::REG_CONTROL, 16'h4041);
    unlock(16'hc041);
    @(negedge clk_sys);
    chk1("erase", 1'b1, array_erase);
    chk("erase panel", 24'h000009, 24'(array_panel));
    chk("erase row", 24'h000002, 24'(array_row));
    @(posedge clk_sys);
    idle(OPC + 5);
    chk("erase cycles", 24'(OPC), 24'(erase_n));
    chk("program idle", 24'h000000, 24'(prog_n));
    unlock(16'hc041);
    warm_reset <= 1'b1;
    @(posedge clk_sys);
    warm_reset <= 1'b0;
    @(negedge clk_sys);
    chk1("stall after abort", 1'b0, cpu_stall);
    @(posedge clk_sys);
    rd(flash_pkg::REG_CONTROL, rv);
    chk1("abort flag", 1'b1, rv[13]);
    chk1("trigger after abort", 1'b0, rv[15]);
    rd(flash_pkg::REG_ADDR_LOW, rv);
    chk("addr kept", 24'h002080, 24'(rv));
    $display("test erase and abort done");
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_table_read();
    t_fill();
    t_locked();
    t_program();
    t_erase();
    end_sim();
  end
endmodule
